// >>> flow_readout_pkg.sv
// shared constants and types for the flow sensor two-wire readout
package flow_readout_pkg;

  // bus address and direction
  localparam logic [6:0] DEV_ADDR      = 7'h50;
  localparam logic       DIR_READ      = 1'b1;

  // bit counting inside one byte
  localparam logic [3:0] BIT_CNT_ZERO  = 4'h0;
  localparam logic [3:0] BIT_CNT_ONE   = 4'h1;
  localparam logic [3:0] BIT_CNT_LAST  = 4'h7;
  localparam logic [3:0] BIT_CNT_BYTE  = 4'h8;

  // byte order of one read frame
  localparam logic [1:0] IDX_CHK       = 2'h0;
  localparam logic [1:0] IDX_HI        = 2'h1;
  localparam logic [1:0] IDX_LO        = 2'h2;
  localparam logic [1:0] IDX_ONE       = 2'h1;

  // flow value layout
  localparam int         FLOW_W        = 12;
  localparam logic [3:0] HI_PAD        = 4'h0;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [7:0] BYTE_ONES     = 8'hff;

  // line levels
  localparam logic       LINE_HIGH     = 1'b1;
  localparam logic       LINE_LOW      = 1'b0;

  // buffer in the measurement path
  localparam int         BUF_DEPTH     = 2;

  typedef struct packed {
    logic [FLOW_W-1:0] count;
  } flow_word_t;

  typedef struct packed {
    logic [7:0] chk;
    logic [7:0] hi;
    logic [7:0] lo;
  } frame_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_IGNORE
  } link_state_t;

endpackage

// >>> sample_buffer.sv
// two-entry valid/ready buffer for flow measurements
module sample_buffer #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [PW-1:0] PTR_ZERO = '0;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             not_full_r;
  wire              push = in_valid_in && not_full_r;
  wire              pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = not_full_r;
  assign out_valid_out = (cnt_r != CNT_ZERO);
  assign out_data_out  = mem_r[rd_ptr_r];
  assign cnt_nxt       = cnt_r + CW'(push) - CW'(pop);

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_ptr_r   <= PTR_ZERO;
      rd_ptr_r   <= PTR_ZERO;
      cnt_r      <= CNT_ZERO;
      not_full_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? PTR_ZERO : wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? PTR_ZERO : rd_ptr_r + PW'(1);
      end
      cnt_r      <= cnt_nxt;
      not_full_r <= (cnt_nxt != CNT_FULL);
    end
  end

endmodule

// >>> flow_i2c_readout.sv
// two-wire slave that returns checksum and flow bytes of the latest measurement
module flow_i2c_readout (
  input  wire logic                        mclk_in,
  input  wire logic                        reset_in,
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe_n_out,
  input  wire flow_readout_pkg::flow_word_t sample_in,
  input  wire logic                        sample_valid_in,
  output logic                             sample_ready_out,
  output logic                             busy_out,
  output logic                             read_done_out,
  output logic                             master_nack_out,
  output flow_readout_pkg::flow_word_t     latest_out
);
  import flow_readout_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic frame_t build_frame(input flow_word_t w);
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] sum;
    hi = {HI_PAD, w.count[FLOW_W-1:8]};
    lo = w.count[7:0];
    sum = hi + lo;
    build_frame.hi  = hi;
    build_frame.lo  = lo;
    build_frame.chk = BYTE_ZERO - sum;
  endfunction

  // byte slots past the frame read as all ones, like a released line
  function automatic logic [7:0] frame_byte(input frame_t f, input logic [1:0] idx);
    logic [7:0] b;
    b = BYTE_ONES;
    if (idx == IDX_CHK) begin
      b = f.chk;
    end else if (idx == IDX_HI) begin
      b = f.hi;
    end else if (idx == IDX_LO) begin
      b = f.lo;
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus event detection

  logic scl_meta_r;
  logic scl_sync_r;
  logic scl_prev_r;
  logic sda_meta_r;
  logic sda_sync_r;
  logic sda_prev_r;

  // the 200 MHz sampler sees many cycles in each bus clock phase
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      scl_meta_r <= LINE_HIGH;
      scl_sync_r <= LINE_HIGH;
      scl_prev_r <= LINE_HIGH;
      sda_meta_r <= LINE_HIGH;
      sda_sync_r <= LINE_HIGH;
      sda_prev_r <= LINE_HIGH;
    end else begin
      scl_meta_r <= scl_in;
      scl_sync_r <= scl_meta_r;
      scl_prev_r <= scl_sync_r;
      sda_meta_r <= sda_in;
      sda_sync_r <= sda_meta_r;
      sda_prev_r <= sda_sync_r;
    end
  end

  // both lines pass the same two flops, so their order is kept for start and stop
  wire scl_rise   = scl_sync_r && !scl_prev_r;
  wire scl_fall   = !scl_sync_r && scl_prev_r;
  wire scl_steady = scl_sync_r && scl_prev_r;
  wire start_cond = scl_steady && sda_prev_r && !sda_sync_r;
  wire stop_cond  = scl_steady && !sda_prev_r && sda_sync_r;

  ////////////////////////////////////////////////////////////////////////////
  // measurement path: buffer drains into the newest-value register

  link_state_t state_r;
  link_state_t state_nxt;
  flow_word_t  buf_data;
  logic        buf_valid;
  logic        buf_ready;
  flow_word_t  latest_r;

  // frozen while a read to us runs, so the buffer fills and stalls the source
  assign buf_ready = (state_r == ST_IDLE) || (state_r == ST_IGNORE);
  wire   buf_pop   = buf_valid && buf_ready;

  sample_buffer #(
    .WIDTH ($bits(flow_word_t)),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .mclk_in       (mclk_in),
    .reset_in      (reset_in),
    .in_data_in    (sample_in),
    .in_valid_in   (sample_valid_in),
    .in_ready_out  (sample_ready_out),
    .out_data_out  (buf_data),
    .out_valid_out (buf_valid),
    .out_ready_in  (buf_ready)
  );

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      latest_r <= '0;
    end else if (buf_pop) begin
      latest_r <= buf_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link state machine

  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [1:0] byte_idx_r;
  logic [1:0] byte_idx_nxt;
  frame_t     frame_r;
  frame_t     frame_nxt;
  logic       oe_n_r;
  logic       oe_n_nxt;
  logic       acked_r;
  logic       acked_nxt;
  logic       done_r;
  logic       done_nxt;
  logic       nack_r;
  logic       nack_nxt;

  wire [7:0] rx_byte  = {shift_r[6:0], sda_sync_r};
  wire       addr_hit = (shift_r[7:1] == DEV_ADDR) && (shift_r[0] == DIR_READ);
  wire [1:0] next_idx = byte_idx_r + IDX_ONE;
  wire [7:0] next_tx  = frame_byte(frame_r, next_idx);
  wire [7:0] first_tx = frame_byte(frame_r, IDX_CHK);

  always_comb begin
    state_nxt    = state_r;
    bit_cnt_nxt  = bit_cnt_r;
    shift_nxt    = shift_r;
    byte_idx_nxt = byte_idx_r;
    frame_nxt    = frame_r;
    oe_n_nxt     = oe_n_r;
    acked_nxt    = acked_r;
    done_nxt     = 1'b0;
    nack_nxt     = nack_r;
    // stop and start win over any state, so a cut frame never leaves the line held
    if (stop_cond) begin
      state_nxt = ST_IDLE;
      oe_n_nxt  = LINE_HIGH;
    end else if (start_cond) begin
      state_nxt   = ST_ADDR;
      bit_cnt_nxt = BIT_CNT_ZERO;
      oe_n_nxt    = LINE_HIGH;
      nack_nxt    = 1'b0;
    end else begin
      case (state_r)
        ST_ADDR: begin
          if (scl_rise && bit_cnt_r != BIT_CNT_BYTE) begin
            shift_nxt   = rx_byte;
            bit_cnt_nxt = bit_cnt_r + BIT_CNT_ONE;
          end else if (scl_fall && bit_cnt_r == BIT_CNT_BYTE) begin
            if (addr_hit) begin
              oe_n_nxt  = LINE_LOW;
              // frozen here so the three bytes always describe one measurement
              frame_nxt = build_frame(latest_r);
              state_nxt = ST_ADDR_ACK;
            end else begin
              state_nxt = ST_IGNORE;
            end
          end
        end
        // the ack is let go at the next fall, which also puts out the first data bit
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            byte_idx_nxt = IDX_CHK;
            shift_nxt    = first_tx;
            oe_n_nxt     = first_tx[7];
            bit_cnt_nxt  = BIT_CNT_ZERO;
            state_nxt    = ST_TX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            // the eighth fall frees the line so the master owns the response slot
            if (bit_cnt_r == BIT_CNT_LAST) begin
              oe_n_nxt  = LINE_HIGH;
              state_nxt = ST_TX_ACK;
            end else begin
              shift_nxt   = {shift_r[6:0], LINE_HIGH};
              oe_n_nxt    = shift_r[6];
              bit_cnt_nxt = bit_cnt_r + BIT_CNT_ONE;
            end
          end
        end
        // the master's answer is taken on the rise and acted on at the following fall
        ST_TX_ACK: begin
          if (scl_rise) begin
            acked_nxt = (sda_sync_r == LINE_LOW);
          end else if (scl_fall) begin
            if (acked_r && byte_idx_r != IDX_LO) begin
              byte_idx_nxt = next_idx;
              shift_nxt    = next_tx;
              oe_n_nxt     = next_tx[7];
              bit_cnt_nxt  = BIT_CNT_ZERO;
              state_nxt    = ST_TX;
            end else begin
              done_nxt  = 1'b1;
              nack_nxt  = !acked_r;
              state_nxt = ST_IGNORE;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= BIT_CNT_ZERO;
      shift_r    <= BYTE_ZERO;
      byte_idx_r <= IDX_CHK;
      acked_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      shift_r    <= shift_nxt;
      byte_idx_r <= byte_idx_nxt;
      acked_r    <= acked_nxt;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      frame_r <= '0;
      oe_n_r  <= LINE_HIGH;
      done_r  <= 1'b0;
      nack_r  <= 1'b0;
    end else begin
      frame_r <= frame_nxt;
      oe_n_r  <= oe_n_nxt;
      done_r  <= done_nxt;
      nack_r  <= nack_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // the drive value is fixed low; the enable alone carries each bit
  logic sda_lvl_r;
  logic busy_r;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sda_lvl_r <= LINE_LOW;
      busy_r    <= 1'b0;
    end else begin
      sda_lvl_r <= LINE_LOW;
      busy_r    <= !buf_ready;
    end
  end

  // open drain: only ever pulls low, enable is active low
  assign sda_out         = sda_lvl_r;
  assign sda_oe_n_out    = oe_n_r;
  assign busy_out        = busy_r;
  assign read_done_out   = done_r;
  assign master_nack_out = nack_r;
  assign latest_out      = latest_r;

endmodule

// >>> flow_readout_asserts.sv
// concurrent checks on the ports of the two-wire flow readout
module flow_readout_checker
  import flow_readout_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       reset_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n_out,
  input wire flow_word_t sample_in,
  input wire logic       sample_valid_in,
  input wire logic       sample_ready_out,
  input wire logic       busy_out,
  input wire logic       read_done_out,
  input wire logic       master_nack_out,
  input wire flow_word_t latest_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  a_drive_low: assert property (sda_out == LINE_LOW)
    else $error("data drive value not low");
  a_move_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("data line moved with clock high");
  a_done_pulse: assert property (read_done_out |-> !scl_in ##1 !read_done_out)
    else $error("read end not a single pulse at clock low");
  a_done_in_read: assert property (read_done_out |-> $past(busy_out))
    else $error("read end outside a read");
  a_drive_in_read: assert property ($fell(sda_oe_n_out) |-> busy_out)
    else $error("data pulled low outside an addressed read");
  a_nack_at_done: assert property ($rose(master_nack_out) |-> read_done_out)
    else $error("master nack flag set away from read end");
  a_hold_in_read: assert property (
    busy_out && $past(busy_out) |-> $stable(latest_out))
    else $error("newest word changed during a read");
  a_drain_idle: assert property (
    !sample_ready_out && !busy_out ##1 !busy_out |-> ##[0:2] sample_ready_out)
    else $error("buffer does not drain while idle");

  c_read_done: cover property (read_done_out);
  c_ack: cover property ($fell(sda_oe_n_out));
  c_full: cover property (!sample_ready_out && sample_valid_in);
endmodule

bind flow_i2c_readout flow_readout_checker u_flow_readout_checker (
  .mclk_in(mclk_in), .reset_in(reset_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .sample_in(sample_in),
  .sample_valid_in(sample_valid_in), .sample_ready_out(sample_ready_out),
  .busy_out(busy_out), .read_done_out(read_done_out),
  .master_nack_out(master_nack_out), .latest_out(latest_out));

// >>> flow_bus_master.sv
// behavioural two-wire bus master that reads flow frames
module flow_bus_master (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      pull_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import flow_readout_pkg::*;

  initial begin
    scl_out = 1'b1;
    pull_out = 1'b0;
  end
  // data set in the low phase, sampled in the middle of the high phase
  // pins move by non-blocking assignment so they never race the sampling edge
  task automatic slot(input logic b, output logic r);
    #10 pull_out <= !b;
    #30 scl_out <= 1'b1;
    #20 r = sda_in;
    #20 scl_out <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) slot(d[i], q[i]);
    slot(ak, r);
  endtask
  task automatic read3(input logic [6:0] a, input logic rw, output logic ak, output frame_t f);
    logic [7:0] q;
    logic       r;
    pull_out <= 1'b1;
    #20 scl_out <= 1'b0;
    xfer({a, rw}, 1'b1, q, ak);
    f = {3{BYTE_ONES}};
    if (ak == LINE_LOW) begin
      xfer(BYTE_ONES, 1'b0, f.chk, r);
      xfer(BYTE_ONES, 1'b0, f.hi, r);
      xfer(BYTE_ONES, 1'b1, f.lo, r);
    end
    #10 pull_out <= 1'b1;
    #30 scl_out <= 1'b1;
    #20 pull_out <= 1'b0;
    #40;
  endtask
endmodule

// >>> flow_sensor_i2c_readout_test.sv
// self-checking bench for the two-wire flow readout
module flow_sensor_i2c_readout_test;
  timeunit 1ns;
  timeprecision 100ps;
  import flow_readout_pkg::*;

  logic        mclk_in;
  logic        reset_in;
  logic        valid;
  flow_word_t  sample;
  wire         scl, sda, oe_n, drv, ready, busy, done, nack, pull;
  flow_word_t  latest;
  int          n_mismatch, cmp_count, n_done;
  logic [15:0] seed;

  flow_i2c_readout u_flow_i2c_readout (
    .mclk_in(mclk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda), .sda_out(drv),
    .sda_oe_n_out(oe_n), .sample_in(sample), .sample_valid_in(valid),
    .sample_ready_out(ready), .busy_out(busy), .read_done_out(done),
    .master_nack_out(nack), .latest_out(latest));
  flow_bus_master u_flow_bus_master (.sda_in(sda), .scl_out(scl), .pull_out(pull));
  // open-drain data line with pull-up
  assign sda = (pull || (!oe_n && !drv)) ? LINE_LOW : LINE_HIGH;

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = !mclk_in;
  end
  always @(posedge mclk_in) if (done === 1'b1) n_done <= n_done + 1;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic frame_t exp_frame(input logic [11:0] w);
    frame_t f;
    f.hi = {HI_PAD, w[11:8]};
    f.lo = w[7:0];
    f.chk = BYTE_ZERO - (f.hi + f.lo);
    return f;
  endfunction
  task automatic check(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic offer(input logic [11:0] w);
    int n;
    n = 0;
    @(posedge mclk_in);
    sample <= flow_word_t'(w);
    valid <= 1'b1;
    @(posedge mclk_in);
    while (ready !== 1'b1 && n < 50) begin
      @(posedge mclk_in);
      n++;
    end
    check(n < 50, "word not taken");
    if (n == 50) give_verdict();
    valid <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    frame_t      f;
    logic        ak;
    logic [11:0] w, w2, w0;
    reset_in = 1'b1;
    valid = 1'b0;
    sample = '0;
    n_mismatch = 0;
    cmp_count = 0;
    n_done = 0;
    seed = 16'h0022;
    repeat (20) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : seed[11:0];
      seed = lfsr(seed);
      offer(w);
      repeat (4) @(posedge mclk_in);
      check(latest.count === w, "newest word not held");
      u_flow_bus_master.read3(DEV_ADDR, DIR_READ, ak, f);
      check(ak === LINE_LOW, "address not acknowledged");
      check(f === exp_frame(w), "frame bytes wrong");
      check(f.chk + f.hi + f.lo === BYTE_ZERO, "checksum does not cancel");
      check(nack === 1'b1 && n_done == i + 1, "read end not flagged");
    end
    for (int i = 0; i < 2; i++) begin
      u_flow_bus_master.read3(i ? DEV_ADDR : DEV_ADDR ^ 7'h01, i ? !DIR_READ : DIR_READ, ak, f);
      check(ak === LINE_HIGH && busy === 1'b0 && nack === 1'b0 && n_done == 6,
            "foreign request answered");
    end
    w0 = w;
    w = seed[11:0];
    w2 = ~w;
    fork
      u_flow_bus_master.read3(DEV_ADDR, DIR_READ, ak, f);
      begin
        repeat (300) @(posedge mclk_in);
        check(busy === 1'b1, "read not flagged busy");
        offer(w);
        offer(w2);
        @(posedge mclk_in);
        valid <= 1'b1;
        repeat (4) @(posedge mclk_in);
        check(ready === 1'b0, "third word taken while full");
        valid <= 1'b0;
        check(latest.count === w0, "newest word moved during read");
      end
    join
    repeat (8) @(posedge mclk_in);
    check(f === exp_frame(w0) && latest.count === w2,
          "snapshot or drain wrong");
    check(ready === 1'b1, "buffer not drained");
    give_verdict();
  end
  initial begin
    #200000;
    check(1'b0, "run did not finish");
    give_verdict();
  end
endmodule
